/* src/ccu_pkg.sv */
// Purpose: Shared constants and carriers of the capture/compare unit pair
// Assumes: AHB-Lite word registers, one clock
// Notes:   Byte addresses are word aligned
package ccu_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_U1_CTRL = 8'h00;
    localparam logic [7:0] OFF_U1_LOW  = 8'h04;
    localparam logic [7:0] OFF_U1_HIGH = 8'h08;
    localparam logic [7:0] OFF_U2_CTRL = 8'h0C;
    localparam logic [7:0] OFF_U2_LOW  = 8'h10;
    localparam logic [7:0] OFF_U2_HIGH = 8'h14;
    localparam logic [7:0] OFF_T3_CTRL = 8'h18;
    localparam logic [7:0] OFF_FLAGS   = 8'h1C;
    localparam logic [7:0] OFF_ENABLES = 8'h20;
    // ==========================================================
    // Field positions
    localparam int SEL_HIGH_BIT = 6;
    localparam int SEL_LOW_BIT  = 3;
    localparam int CTRL_BITS    = 6;
    // ==========================================================
    // Reset values
    localparam logic [7:0]  RST_CTRL  = 8'h00;
    localparam logic [15:0] RST_VALUE = 16'h0000;
    localparam logic [7:0]  RST_TCON  = 8'h00;
    localparam logic [3:0]  RST_PRE   = 4'h0;
    // ==========================================================
    // Mode select codes
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH  = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
    localparam logic [3:0] MODE_CMP_LOW  = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    // ==========================================================
    // Prescaler last counts
    localparam logic [3:0] PRE4_LAST  = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [15:0] first_timer_count;
        logic [15:0] second_timer_count;
    } ccu_timers_s;
    typedef struct packed {
        logic [1:0] timer_reset;
        logic       adc_start;
    } ccu_events_s;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] value;
        logic [3:0]  pre;
        logic        latch;
        logic        flag;
        logic        en;
        logic        match_prev;
    } ccu_unit_s;
endpackage

/* src/ccu_top.sv */
// Purpose: Two capture/compare units behind an AHB-Lite slave
// Assumes: Timer counts and port latches on hclk; unit pins asynchronous
// Notes:   Zero wait states, response always OKAY
// Contract
// [R1] Rewriting a capture mode may set the unit flag falsely.
// [R2] Software keeps enable clear and clears flag around mode changes.
// [R3] Four capture prescalers live inside the 4-bit mode field.
// [R4] Prescaler counter clears when unit off, capture left, or reset.
// [R5] Prescaler-to-prescaler change keeps count and may set flag.
// [R6] Software turns unit off, then writes new mode in one write.
// [R7] Compare mode matches value register against selected 16-bit timer.
// [R8] Match drives pin high, low, toggles or leaves port latch.
// [R9] Flag sets on the same clock the match acts on the pin.
// [R10] Writing zero to unit two control forces its compare latch low.
// [R11] Software runs selected timer synchronously when compare is used.
// [R12] Mode 1010 leaves pin alone; flag only, request gated by enable.
// [R13] Mode 1011 match issues a special event trigger pulse.
// [R14] Trigger resets the count of the unit's selected timer.
// [R15] Unit two trigger starts conversion only if converter enabled.
// [R16] Software sets pin direction to output for compare.
// [R17] Modes 0100-0111: falling, rising, 4th rising, 16th rising capture.
// [R18] 1000 starts low, goes high; 1001 starts high, goes low.
// [R19] Capture latches selected timer and sets flag, overwriting old.
// [R20] Timer select bits in timer three control pick each unit's timer.
// [R21] Pin input synchronised before edge detection, one count per edge.
// [R22] Mode 0010 toggles the pin on match.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
module ccu_top
(
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Timers and converter
    input  wire ccu_pkg::ccu_timers_s timers,
    input  wire logic                adc_enabled,
    output ccu_pkg::ccu_events_s     events,
    // Unit pins and port latches
    input  wire logic [1:0]          unit_pin_in,
    input  wire logic [1:0]          port_latch,
    output logic [1:0]               unit_pin_out,
    output logic [1:0]               unit_pin_drive,
    // Interrupt requests to the core
    output logic [1:0]               unit_irq_req
);
    // ==========================================================
    // Whole state of the block
    typedef struct packed {
        ccu_pkg::ccu_unit_s [1:0] u;
        logic [7:0]           tcon;
        logic [1:0]           sync1;
        logic [1:0]           sync2;
        logic [1:0]           pin_prev;
        logic                 wr_pend;
        logic [7:0]           wr_addr;
        logic [31:0]          rdata;
        ccu_pkg::ccu_events_s ev;
    } ccu_state_s;

    ccu_state_s st_q;
    ccu_state_s st_d;

    // ==========================================================
    // Helpers
    // Unit uses the second timer when this returns one
    function automatic logic ccu_sel_second(input logic [7:0] tcon, input int unit);
        logic r;
        r = 1'b0;
        if (tcon[ccu_pkg::SEL_HIGH_BIT])
        begin
            r = 1'b1;
        end
        else if (tcon[ccu_pkg::SEL_LOW_BIT])
        begin
            r = (unit == 1);
        end
        return r; // R20
    endfunction

    function automatic logic ccu_is_capture(input logic [3:0] m);
        return (m[3:2] == 2'b01); // R3
    endfunction

    function automatic logic ccu_is_compare(input logic [3:0] m);
        return (m[3:2] == 2'b10) || (m == ccu_pkg::MODE_TOGGLE);
    endfunction

    function automatic logic [31:0] ccu_read(input ccu_state_s s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ccu_pkg::OFF_U1_CTRL: r = {24'h000000, s.u[0].ctrl};
            ccu_pkg::OFF_U1_LOW:  r = {24'h000000, s.u[0].value[7:0]};
            ccu_pkg::OFF_U1_HIGH: r = {24'h000000, s.u[0].value[15:8]};
            ccu_pkg::OFF_U2_CTRL: r = {24'h000000, s.u[1].ctrl};
            ccu_pkg::OFF_U2_LOW:  r = {24'h000000, s.u[1].value[7:0]};
            ccu_pkg::OFF_U2_HIGH: r = {24'h000000, s.u[1].value[15:8]};
            ccu_pkg::OFF_T3_CTRL: r = {24'h000000, s.tcon};
            ccu_pkg::OFF_FLAGS:   r = {30'h0000000, s.u[1].flag, s.u[0].flag};
            ccu_pkg::OFF_ENABLES: r = {30'h0000000, s.u[1].en, s.u[0].en};
            default:              r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Next-state logic
    // Order: bus write first, hardware events after, so events win, except a 4th/16th capture edge during a write that leaves capture
    always_comb
    begin
        logic [3:0]  old_m;
        logic [3:0]  new_m;
        logic [3:0]  m;
        logic [7:0]  wctrl;
        logic [15:0] tval;
        logic        rise;
        logic        fall;
        logic        hit;
        logic        cap;
        logic        sec;
        logic        wr;
        old_m = 4'h0;
        new_m = 4'h0;
        m     = 4'h0;
        wctrl = 8'h00;
        tval  = 16'h0000;
        rise  = 1'b0;
        fall  = 1'b0;
        hit   = 1'b0;
        cap   = 1'b0;
        sec   = 1'b0;
        wr    = 1'b0;
        st_d  = st_q;

        // Two-stage pin synchroniser; stage one feeds stage two only
        st_d.sync1    = unit_pin_in; // R21
        st_d.sync2    = st_q.sync1; // R21
        st_d.pin_prev = st_q.sync2;
        st_d.ev       = '0;

        // Address phase: capture target, preload read data
        st_d.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            st_d.wr_pend = hwrite && (hsize == 3'b010);
            st_d.wr_addr = {haddr[7:2], 2'b00};
            st_d.rdata   = ccu_read(st_q, {haddr[7:2], 2'b00});
        end

        // Timer three control and enables are plain stores
        if (st_q.wr_pend && st_q.wr_addr == ccu_pkg::OFF_T3_CTRL)
        begin
            st_d.tcon = hwdata[7:0];
        end
        if (st_q.wr_pend && st_q.wr_addr == ccu_pkg::OFF_ENABLES)
        begin
            st_d.u[0].en = hwdata[0];
            st_d.u[1].en = hwdata[1];
        end

        for (int i = 0; i < 2; i++)
        begin
            // Software side of unit i
            wctrl = {2'b00, hwdata[ccu_pkg::CTRL_BITS-1:0]};
            wr    = st_q.wr_pend &&
                    st_q.wr_addr == (i == 0 ? ccu_pkg::OFF_U1_CTRL : ccu_pkg::OFF_U2_CTRL);
            old_m = st_q.u[i].ctrl[3:0];
            new_m = wctrl[3:0];
            if (wr)
            begin
                st_d.u[i].ctrl = wctrl;
                // Leaving capture or switching off clears the prescaler
                if (!ccu_is_capture(new_m))
                begin
                    st_d.u[i].pre = ccu_pkg::RST_PRE; // R4
                end
                // Prescaler-to-prescaler change keeps the count
                // Compare start levels are set when the mode is written
                if (new_m == ccu_pkg::MODE_CMP_HIGH && old_m != new_m)
                begin
                    st_d.u[i].latch = 1'b0; // R18
                end
                if (new_m == ccu_pkg::MODE_CMP_LOW && old_m != new_m)
                begin
                    st_d.u[i].latch = 1'b1; // R18
                end
                if (wctrl == 8'h00)
                begin
                    st_d.u[i].latch = 1'b0; // R10
                end
            end
            if (st_q.wr_pend &&
                st_q.wr_addr == (i == 0 ? ccu_pkg::OFF_U1_LOW : ccu_pkg::OFF_U2_LOW))
            begin
                st_d.u[i].value[7:0] = hwdata[7:0];
            end
            if (st_q.wr_pend &&
                st_q.wr_addr == (i == 0 ? ccu_pkg::OFF_U1_HIGH : ccu_pkg::OFF_U2_HIGH))
            begin
                st_d.u[i].value[15:8] = hwdata[7:0];
            end
            if (st_q.wr_pend && st_q.wr_addr == ccu_pkg::OFF_FLAGS)
            begin
                st_d.u[i].flag = hwdata[i];
            end

            // Hardware side of unit i, running on the current mode
            m    = st_q.u[i].ctrl[3:0];
            sec  = ccu_sel_second(st_q.tcon, i); // R20
            tval = sec ? timers.second_timer_count : timers.first_timer_count;
            rise = st_q.sync2[i] && !st_q.pin_prev[i];
            fall = !st_q.sync2[i] && st_q.pin_prev[i];

            // Capture: rewriting a capture mode raises a false request
            if (wr && ccu_is_capture(old_m) && new_m != old_m && new_m != ccu_pkg::MODE_OFF)
            begin
                st_d.u[i].flag = 1'b1; // R1 R5
            end
            cap = 1'b0;
            case (m)
                ccu_pkg::MODE_CAP_FALL: cap = fall; // R17
                ccu_pkg::MODE_CAP_RISE: cap = rise; // R17
                ccu_pkg::MODE_CAP_4TH,
                ccu_pkg::MODE_CAP_16TH:
                begin
                    if (rise && !(wr && !ccu_is_capture(new_m)))
                    begin
                        if (st_q.u[i].pre == (m == ccu_pkg::MODE_CAP_4TH ?
                                              ccu_pkg::PRE4_LAST : ccu_pkg::PRE16_LAST))
                        begin
                            cap = 1'b1; // R17
                            st_d.u[i].pre = ccu_pkg::RST_PRE;
                        end
                        else
                        begin
                            st_d.u[i].pre = st_q.u[i].pre + 4'h1;
                        end
                    end
                end
                default: cap = 1'b0;
            endcase
            if (cap)
            begin
                st_d.u[i].value = tval; // R19
                st_d.u[i].flag  = 1'b1; // R19
            end

            // Compare acts once, on the first cycle of a match
            hit = ccu_is_compare(m) && (st_q.u[i].value == tval); // R7
            st_d.u[i].match_prev = hit;
            if (hit && !st_q.u[i].match_prev)
            begin
                st_d.u[i].flag = 1'b1; // R9 R12
                case (m)
                    ccu_pkg::MODE_CMP_HIGH: st_d.u[i].latch = 1'b1; // R8 R18
                    ccu_pkg::MODE_CMP_LOW:  st_d.u[i].latch = 1'b0; // R8 R18
                    ccu_pkg::MODE_TOGGLE:   st_d.u[i].latch = !st_q.u[i].latch; // R22
                    ccu_pkg::MODE_CMP_TRIG:
                    begin
                        st_d.ev.timer_reset[sec] = 1'b1; // R13 R14
                        if (i == 1 && adc_enabled)
                        begin
                            st_d.ev.adc_start = 1'b1; // R15
                        end
                    end
                    default: st_d.u[i].latch = st_q.u[i].latch;
                endcase
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                st_q.u[i].ctrl       <= ccu_pkg::RST_CTRL;
                st_q.u[i].value      <= ccu_pkg::RST_VALUE;
                st_q.u[i].pre        <= ccu_pkg::RST_PRE; // R4
                st_q.u[i].latch      <= 1'b0;
                st_q.u[i].flag       <= 1'b0;
                st_q.u[i].en         <= 1'b0;
                st_q.u[i].match_prev <= 1'b0;
            end
            st_q.tcon     <= ccu_pkg::RST_TCON;
            st_q.sync1    <= 2'b00;
            st_q.sync2    <= 2'b00;
            st_q.pin_prev <= 2'b00;
            st_q.wr_pend  <= 1'b0;
            st_q.wr_addr  <= 8'h00;
            st_q.rdata    <= 32'h0000_0000;
            st_q.ev       <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    // Slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_q.rdata;
    assign events    = st_q.ev;

    // Pin follows the compare latch only in pin-driving compare modes
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            unit_pin_drive[i] = (st_q.u[i].ctrl[3:0] == ccu_pkg::MODE_CMP_HIGH) ||
                                (st_q.u[i].ctrl[3:0] == ccu_pkg::MODE_CMP_LOW)  ||
                                (st_q.u[i].ctrl[3:0] == ccu_pkg::MODE_TOGGLE); // R8
            unit_pin_out[i]   = unit_pin_drive[i] ? st_q.u[i].latch : port_latch[i]; // R12
            unit_irq_req[i]   = st_q.u[i].flag && st_q.u[i].en; // R12
        end
    end
endmodule // ccu_top

/* verif/ccu_far_model.sv */
// Purpose: Far-side timer pair for the capture/compare units
// Assumes: Timers count on hclk, as the block expects
// Notes:   The bench pauses counting with run
module ccu_far_model
(
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // Bench control
    input  wire logic                 run,
    // Block side
    input  wire ccu_pkg::ccu_events_s events,
    output ccu_pkg::ccu_timers_s      timers
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Synchronous counting; trigger clears the count
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            timers <= '0;
        else
        begin
            if (events.timer_reset[0])
                timers.first_timer_count <= 16'h0000;
            else if (run)
                timers.first_timer_count <= timers.first_timer_count + 16'h0001;
            if (events.timer_reset[1])
                timers.second_timer_count <= 16'h0000;
            else if (run)
                timers.second_timer_count <= timers.second_timer_count + 16'h0001;
        end
    end
endmodule // ccu_far_model

/* verif/ccu_asserts.sv */
// Purpose: Port-level checks of the capture/compare pair
// Assumes: One clock; mode fields shadowed from bus writes
// Notes:   Only word writes reach the shadow, as in the block
module ccu_asserts
(
    // Clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // Bus
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic [31:0]          hrdata,
    // Block side
    input wire logic                 adc_enabled,
    input wire ccu_pkg::ccu_events_s events,
    input wire logic [1:0]           port_latch,
    input wire logic [1:0]           unit_pin_out,
    input wire logic [1:0]           unit_pin_drive
);
    logic       ph_q;
    logic       wr_q;
    logic [7:0] ad_q;
    logic [3:0] m1_q;
    logic [3:0] m2_q;
    // ==========================================
    // Mode shadow, stored at the data-phase edge like the block
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            m1_q <= 4'h0;
            m2_q <= 4'h0;
        end
        else
        begin
            ph_q <= hsel & htrans[1] & hready;
            wr_q <= hwrite && hsize == 3'h2;
            ad_q <= haddr[7:0];
            if (ph_q && wr_q && ad_q == ccu_pkg::OFF_U1_CTRL)
                m1_q <= hwdata[3:0];
            if (ph_q && wr_q && ad_q == ccu_pkg::OFF_U2_CTRL)
                m2_q <= hwdata[3:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_pulse;
        events.timer_reset != 2'b00 ##1 events.timer_reset == 2'b00;
    endsequence
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    property p_unmapped;
        ph_q && !wr_q && ad_q >= 8'h24 |-> hrdata == 32'h0;
    endproperty
    property p_drive;
        unit_pin_drive == {m2_q inside {4'h8, 4'h9, 4'h2}, m1_q inside {4'h8, 4'h9, 4'h2}};
    endproperty
    property p_pass;
        ((~unit_pin_drive) & (unit_pin_out ^ port_latch)) == 2'b00;
    endproperty
    property p_init;
        $changed(m1_q) && m1_q inside {4'h8, 4'h9} |-> unit_pin_out[0] == m1_q[0];
    endproperty
    property p_trig_one;
        events.timer_reset != 2'b00 |-> s_pulse;
    endproperty
    property p_trig_cause;
        events.timer_reset != 2'b00 |-> $past(m1_q == 4'hB || m2_q == 4'hB);
    endproperty
    property p_adc;
        events.adc_start |-> $past(adc_enabled && m2_q == 4'hB) && events.timer_reset != 2'b00;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready/okay");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_drive: assert property (p_drive) else $error("pin drive wrong for mode");
    a_pass: assert property (p_pass) else $error("undriven pin not port latch");
    a_init: assert property (p_init) else $error("compare pin start level wrong");
    a_trig_one: assert property (p_trig_one) else $error("trigger not one cycle");
    a_trig_cause: assert property (p_trig_cause) else $error("trigger off mode");
    a_adc: assert property (p_adc) else $error("conversion start ungated");
endmodule // ccu_asserts

/* verif/ccu_top_bench.sv */
// Purpose: Self-checking bench of the capture/compare pair
// Assumes: Zero-wait slave; timers come from the far-side model
// Notes:   Seeded random data with fixed corner cases
module ccu_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic [31:0]          haddr = 32'h0;
    logic [1:0]           htrans = 2'h0;
    logic                 hwrite = 1'b0;
    logic [2:0]           hsize = 3'h2;
    logic [31:0]          hwdata = 32'h0;
    logic                 hready, hreadyout, hresp;
    logic [31:0]          hrdata, rd;
    logic                 adc_en = 1'b0;
    logic                 run = 1'b1;
    logic [1:0]           pin = 2'b00;
    logic [1:0]           latch = 2'b00;
    logic [1:0]           pout, pdrv, irq;
    ccu_pkg::ccu_timers_s tm;
    ccu_pkg::ccu_events_s ev;
    int                   err_count = 0;
    int                   compares = 0;
    int                   seed = 32'h44ed;
    int                   cyc = 0;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    ccu_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .timers(tm), .adc_enabled(adc_en), .events(ev),
        .unit_pin_in(pin), .port_latch(latch), .unit_pin_out(pout), .unit_pin_drive(pdrv),
        .unit_irq_req(irq));
    ccu_far_model far (.hclk, .hresetn, .run, .events(ev), .timers(tm));
    // ==========================================
    // Checking, bus and expectation helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // Pin level after a match; toggle starts from the cleared latch
    function automatic logic pin_exp(input logic [3:0] m, input logic pl);
        case (m)
            ccu_pkg::MODE_CMP_HIGH: pin_exp = 1'b1;
            ccu_pkg::MODE_CMP_LOW:  pin_exp = 1'b0;
            ccu_pkg::MODE_TOGGLE:   pin_exp = 1'b1;
            default:                pin_exp = pl;
        endcase
    endfunction
    function automatic int edges(input logic [3:0] m);
        edges = m == ccu_pkg::MODE_CAP_4TH ? 4 : m == ccu_pkg::MODE_CAP_16TH ? 16 : 1;
    endfunction
    // Three-cycle levels so the synchroniser sees each edge
    task automatic pulse(input logic idle);
        pin[0] <= ~idle;
        repeat (3) @(posedge hclk);
        pin[0] <= idle;
        repeat (3) @(posedge hclk);
    endtask
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
    end
    // ==========================================
    // Main sequence
    initial
    begin : main
        logic [31:0] v;
        logic [3:0]  m;
        logic [15:0] t;
        logic [3:0]  cm [4];
        int          n;
        cm = '{4'h8, 4'h9, 4'h2, 4'hA};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rdc("reset", 8'(i * 4), 32'h0);
        for (int i = 1; i < 9; i++)
            if (i != 3 && i != 7)
            begin
                v = $random(seed);
                wr(8'(i * 4), v);
                rdc("reg", 8'(i * 4), v & (i == 8 ? 32'h3 : 32'hFF));
                wr(8'(i * 4), 32'h0);
            end
        hsize <= 3'h0;
        wr(8'h04, 32'hFF);
        hsize <= 3'h2;
        rdc("size", 8'h04, 32'h0);
        // Capture: off first so the prescaler restarts from zero
        for (int k = 4; k < 8; k++)
        begin
            m = 4'(k);
            wr(ccu_pkg::OFF_U1_CTRL, 32'h0);
            pin[0] <= (m == ccu_pkg::MODE_CAP_FALL);
            repeat (4) @(posedge hclk);
            wr(ccu_pkg::OFF_U1_CTRL, {28'h0, m});
            wr(ccu_pkg::OFF_FLAGS, 32'h0);
            run <= 1'b0;
            repeat (2) @(negedge hclk);
            t = tm.first_timer_count;
            @(posedge hclk);
            for (n = 1; n < edges(m); n++)
                pulse(m == ccu_pkg::MODE_CAP_FALL);
            rdc("early", ccu_pkg::OFF_FLAGS, 32'h0);
            pulse(m == ccu_pkg::MODE_CAP_FALL);
            rdc("capflag", ccu_pkg::OFF_FLAGS, 32'h1);
            rdc("low", ccu_pkg::OFF_U1_LOW, {24'h0, t[7:0]});
            rdc("high", ccu_pkg::OFF_U1_HIGH, {24'h0, t[15:8]});
            run <= 1'b1;
            repeat (($random(seed) & 15) + 1) @(posedge hclk);
        end
        // Compare actions on unit one
        for (int k = 0; k < 4; k++)
        begin
            m = cm[k];
            v = $random(seed);
            latch <= v[1:0];
            wr(ccu_pkg::OFF_U1_CTRL, 32'h0);
            @(negedge hclk);
            t = tm.first_timer_count + 16'd60;
            wr(ccu_pkg::OFF_U1_LOW, {24'h0, t[7:0]});
            wr(ccu_pkg::OFF_U1_HIGH, {24'h0, t[15:8]});
            wr(ccu_pkg::OFF_ENABLES, {31'h0, m == ccu_pkg::MODE_CMP_SOFT});
            wr(ccu_pkg::OFF_U1_CTRL, {28'h0, m});
            wr(ccu_pkg::OFF_FLAGS, 32'h0);
            @(negedge hclk);
            chk("drive", {31'h0, m != ccu_pkg::MODE_CMP_SOFT}, {31'h0, pdrv[0]});
            v[2] = (m == ccu_pkg::MODE_CMP_SOFT) ? v[0] : ~pin_exp(m, v[0]);
            chk("init", {31'h0, v[2]}, {31'h0, pout[0]});
            n = 0;
            while (tm.first_timer_count != t + 16'd3 && n < 200)
            begin
                @(negedge hclk);
                n++;
            end
            chk("pin", {31'h0, pin_exp(m, v[0])}, {31'h0, pout[0]});
            chk("irq", {31'h0, m == ccu_pkg::MODE_CMP_SOFT}, {31'h0, irq[0]});
            rdc("cmpflag", ccu_pkg::OFF_FLAGS, 32'h1);
        end
        // Special event trigger on unit two, second timer selected
        wr(ccu_pkg::OFF_U1_CTRL, 32'h0);
        wr(ccu_pkg::OFF_T3_CTRL, 32'h8);
        for (int k = 0; k < 2; k++)
        begin
            adc_en <= (k == 0);
            wr(ccu_pkg::OFF_U2_CTRL, 32'h0);
            @(negedge hclk);
            t = tm.second_timer_count + 16'd40;
            wr(ccu_pkg::OFF_U2_LOW, {24'h0, t[7:0]});
            wr(ccu_pkg::OFF_U2_HIGH, {24'h0, t[15:8]});
            wr(ccu_pkg::OFF_U2_CTRL, {28'h0, ccu_pkg::MODE_CMP_TRIG});
            wr(ccu_pkg::OFF_FLAGS, 32'h0);
            n = 0;
            while (ev.timer_reset[1] !== 1'b1 && n < 200)
            begin
                @(negedge hclk);
                n++;
            end
            chk("trig", 32'h2, {30'h0, ev.timer_reset});
            chk("adc", {31'h0, k == 0}, {31'h0, ev.adc_start});
            @(negedge hclk);
            chk("count", 32'h0, {16'h0, tm.second_timer_count});
            rdc("trgflag", ccu_pkg::OFF_FLAGS, 32'h2);
        end
        results();
    end
endmodule // ccu_top_bench
bind ccu_top ccu_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .adc_enabled, .events, .port_latch,
    .unit_pin_out, .unit_pin_drive);
